/* output_driver_pkg.sv */
package output_driver_pkg;

  // ==========================================================
  // register map
  localparam logic [12:0] FIRST_CTRL_ADDR  = 13'h0032;
  localparam logic [12:0] SECOND_CTRL_ADDR = 13'h0034;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam int          NUM_DRIVERS      = 2;

  // ==========================================================
  // control register fields
  localparam int STRENGTH_BIT  = 7;
  localparam int POWERDOWN_BIT = 6;
  localparam int MODE_HI       = 5;
  localparam int MODE_LO       = 3;
  localparam int POLARITY_BIT  = 2;
  localparam int SOURCE_BIT    = 0;

  // ==========================================================
  // mode codes
  localparam logic [2:0] MODE_CMOS_BOTH = 3'h0;
  localparam logic [2:0] MODE_CMOS_POS  = 3'h1;
  localparam logic [2:0] MODE_CMOS_NEG  = 3'h2;
  localparam logic [2:0] MODE_CMOS_OFF  = 3'h3;
  localparam logic [2:0] MODE_LVDS      = 3'h4;
  localparam logic [2:0] MODE_LVPECL    = 3'h5;

  // ==========================================================
  // logic family reported at the ports
  localparam logic [1:0] FAMILY_NONE   = 2'h0;
  localparam logic [1:0] FAMILY_CMOS   = 2'h1;
  localparam logic [1:0] FAMILY_LVDS   = 2'h2;
  localparam logic [1:0] FAMILY_LVPECL = 2'h3;

  // ==========================================================
  // serial port framing
  localparam int         INSTR_BITS = 16;
  localparam int         FRAME_BITS = 24;
  localparam int         READ_BIT   = 15;
  localparam logic [4:0] CNT_INSTR  = 5'h10;
  localparam logic [4:0] CNT_FRAME  = 5'h18;

endpackage : output_driver_pkg

/* output_driver_mode_control.sv */
`timescale 1ns/1ns
module output_driver_mode_control (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_csb_i,
  input  wire logic       spi_sdio_i,
  output logic            spi_sdio_o,
  output logic            spi_sdio_oe_o,
  input  wire logic [2:0] output_mode_strap_pins_i,
  input  wire logic [1:0] clock_data_i,
  output logic      [1:0] pos_o,
  output logic      [1:0] pos_oe_o,
  output logic      [1:0] neg_o,
  output logic      [1:0] neg_oe_o,
  output logic      [3:0] family_o,
  output logic      [1:0] strong_o,
  output logic      [1:0] powerdown_o
);

  localparam int ND = output_driver_pkg::NUM_DRIVERS;

  // ==========================================================
  // functions
  function automatic logic [5:0] strap_decode(input logic [2:0] s);
    case (s)
      3'h0:    strap_decode = {output_driver_pkg::MODE_LVPECL, output_driver_pkg::MODE_LVPECL};
      3'h1:    strap_decode = {output_driver_pkg::MODE_LVDS, output_driver_pkg::MODE_LVPECL};
      3'h2:    strap_decode = {output_driver_pkg::MODE_LVPECL, output_driver_pkg::MODE_LVDS};
      3'h3:    strap_decode = {output_driver_pkg::MODE_CMOS_POS, output_driver_pkg::MODE_LVPECL};
      3'h4:    strap_decode = {output_driver_pkg::MODE_LVDS, output_driver_pkg::MODE_LVDS};
      3'h5:    strap_decode = {output_driver_pkg::MODE_CMOS_POS, output_driver_pkg::MODE_LVDS};
      3'h6:    strap_decode = {output_driver_pkg::MODE_LVDS, output_driver_pkg::MODE_CMOS_POS};
      default: strap_decode = {output_driver_pkg::MODE_CMOS_POS, output_driver_pkg::MODE_CMOS_POS};
    endcase
  endfunction : strap_decode

  // address to driver index, bit 1 flags a hit
  function automatic logic [1:0] addr_decode(input logic [12:0] a);
    if (a == output_driver_pkg::FIRST_CTRL_ADDR) begin
      addr_decode = 2'h2;
    end else if (a == output_driver_pkg::SECOND_CTRL_ADDR) begin
      addr_decode = 2'h3;
    end else begin
      addr_decode = 2'h0;
    end
  endfunction : addr_decode

  // ==========================================================
  // pin synchronisers
  logic [2:0] sclk_sync;
  logic [1:0] csb_sync;
  logic [1:0] sdi_sync;
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic [1:0] data_meta;
  logic [1:0] data_sync;
  logic [2:0] next_sclk_sync;
  logic [1:0] next_csb_sync;
  logic [1:0] next_sdi_sync;

  always_comb begin
    next_sclk_sync = {sclk_sync[1:0], spi_sclk_i};
    next_csb_sync  = {csb_sync[0], spi_csb_i};
    next_sdi_sync  = {sdi_sync[0], spi_sdio_i};
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_sync  <= 3'h0;
      csb_sync   <= 2'h3;
      sdi_sync   <= 2'h0;
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
      data_meta  <= 2'h0;
      data_sync  <= 2'h0;
    end else begin
      sclk_sync  <= next_sclk_sync;
      csb_sync   <= next_csb_sync;
      sdi_sync   <= next_sdi_sync;
      strap_meta <= output_mode_strap_pins_i;
      strap_sync <= strap_meta;
      data_meta  <= clock_data_i;
      data_sync  <= data_meta;
    end
  end

  wire logic sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  wire logic sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  wire logic csb_hi    = csb_sync[1];
  wire logic sdi       = sdi_sync[1];

  // ==========================================================
  // serial port and control registers
  logic [4:0]  bit_cnt;
  logic [15:0] in_shift;
  logic        rd_flag;
  logic [12:0] addr;
  logic [7:0]  rd_shift;
  logic [7:0]  ctrl [ND];
  logic        sdo;
  logic        sdo_oe;
  logic [4:0]  next_bit_cnt;
  logic [15:0] next_in_shift;
  logic        next_rd_flag;
  logic [12:0] next_addr;
  logic [7:0]  next_rd_shift;
  logic [7:0]  next_ctrl [ND];
  logic        next_sdo;
  logic        next_sdo_oe;
  logic [1:0]  hit;
  logic [15:0] shifted;

  always_comb begin
    next_bit_cnt  = bit_cnt;
    next_in_shift = in_shift;
    next_rd_flag  = rd_flag;
    next_addr     = addr;
    next_rd_shift = rd_shift;
    next_ctrl     = ctrl;
    shifted       = {in_shift[14:0], sdi};
    hit           = addr_decode(shifted[12:0]);
    if (csb_hi) begin
      next_bit_cnt = 5'h00;
      next_rd_flag = 1'b0;
    end else begin
      if (sclk_rise && bit_cnt != output_driver_pkg::CNT_FRAME) begin
        next_in_shift = shifted;
        next_bit_cnt  = bit_cnt + 5'h01;
        if (bit_cnt == output_driver_pkg::CNT_INSTR - 5'h01) begin
          next_rd_flag  = shifted[output_driver_pkg::READ_BIT];
          next_addr     = shifted[12:0];
          next_rd_shift = 8'h00;
          if (hit[1]) begin
            next_rd_shift = ctrl[hit[0]];
          end
        end
        if (bit_cnt == output_driver_pkg::CNT_FRAME - 5'h01 && !rd_flag) begin
          hit = addr_decode(addr);
          if (hit[1]) begin
            next_ctrl[hit[0]] = shifted[7:0];
          end
        end
      end
      if (sclk_fall && bit_cnt > output_driver_pkg::CNT_INSTR) begin
        next_rd_shift = {rd_shift[6:0], 1'b0};
      end
    end
    next_sdo    = next_rd_shift[7];
    next_sdo_oe = !csb_hi && next_rd_flag && next_bit_cnt >= output_driver_pkg::CNT_INSTR;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt  <= 5'h00;
      in_shift <= 16'h0000;
      rd_flag  <= 1'b0;
      addr     <= 13'h0000;
      rd_shift <= 8'h00;
      sdo      <= 1'b0;
      sdo_oe   <= 1'b0;
      for (int i = 0; i < ND; i++) begin
        ctrl[i] <= output_driver_pkg::CTRL_RESET;
      end
    end else begin
      bit_cnt  <= next_bit_cnt;
      in_shift <= next_in_shift;
      rd_flag  <= next_rd_flag;
      addr     <= next_addr;
      rd_shift <= next_rd_shift;
      sdo      <= next_sdo;
      sdo_oe   <= next_sdo_oe;
      ctrl     <= next_ctrl;
    end
  end

  assign spi_sdio_o    = sdo;
  assign spi_sdio_oe_o = sdo_oe;

  // ==========================================================
  // driver mode logic
  logic      [5:0] strap_modes;
  wire logic [1:0] next_pos;
  wire logic [1:0] next_pos_oe;
  wire logic [1:0] next_neg;
  wire logic [1:0] next_neg_oe;
  wire logic [3:0] next_family;
  wire logic [1:0] next_strong;
  wire logic [1:0] next_pd;

  generate
    for (genvar d = 0; d < ND; d++) begin : g_drv
      logic [2:0] mode;
      logic       from_reg;
      logic       level;
      logic       drv_pos;
      logic       drv_neg;
      logic       drv_pos_oe;
      logic       drv_neg_oe;
      logic       drv_strong;
      logic       drv_pd;
      logic [1:0] drv_family;
      always_comb begin
        from_reg = ctrl[d][output_driver_pkg::SOURCE_BIT];
        mode     = from_reg ? ctrl[d][output_driver_pkg::MODE_HI:output_driver_pkg::MODE_LO]
                            : strap_modes[d*3 +: 3];
        level      = data_sync[d] ^ ctrl[d][output_driver_pkg::POLARITY_BIT];
        drv_pos    = 1'b0;
        drv_neg    = 1'b0;
        drv_pos_oe = 1'b0;
        drv_neg_oe = 1'b0;
        drv_strong = 1'b0;
        drv_family = output_driver_pkg::FAMILY_NONE;
        case (mode)
          output_driver_pkg::MODE_CMOS_BOTH,
          output_driver_pkg::MODE_CMOS_POS,
          output_driver_pkg::MODE_CMOS_NEG,
          output_driver_pkg::MODE_CMOS_OFF: begin
            drv_family = output_driver_pkg::FAMILY_CMOS;
            drv_pos    = level;
            drv_neg    = level;
            drv_pos_oe = mode == output_driver_pkg::MODE_CMOS_BOTH ||
                         mode == output_driver_pkg::MODE_CMOS_POS;
            drv_neg_oe = mode == output_driver_pkg::MODE_CMOS_BOTH ||
                         mode == output_driver_pkg::MODE_CMOS_NEG ||
                         (!from_reg && mode == output_driver_pkg::MODE_CMOS_POS);
            drv_strong = ctrl[d][output_driver_pkg::STRENGTH_BIT];
          end
          output_driver_pkg::MODE_LVDS: begin
            drv_family = output_driver_pkg::FAMILY_LVDS;
            drv_pos    = data_sync[d];
            drv_neg    = ~data_sync[d];
            drv_pos_oe = 1'b1;
            drv_neg_oe = 1'b1;
            drv_strong = ctrl[d][output_driver_pkg::STRENGTH_BIT];
          end
          output_driver_pkg::MODE_LVPECL: begin
            drv_family = output_driver_pkg::FAMILY_LVPECL;
            drv_pos    = data_sync[d];
            drv_neg    = ~data_sync[d];
            drv_pos_oe = 1'b1;
            drv_neg_oe = 1'b1;
          end
          default: begin
            drv_family = output_driver_pkg::FAMILY_NONE;
          end
        endcase
        drv_pd = ctrl[d][output_driver_pkg::POWERDOWN_BIT];
        if (drv_pd) begin
          drv_pos    = 1'b0;
          drv_neg    = 1'b0;
          drv_pos_oe = 1'b0;
          drv_neg_oe = 1'b0;
        end
      end
      // each driver owns only its own slice of the shared next-value nets
      assign next_pos[d]           = drv_pos;
      assign next_neg[d]           = drv_neg;
      assign next_pos_oe[d]        = drv_pos_oe;
      assign next_neg_oe[d]        = drv_neg_oe;
      assign next_strong[d]        = drv_strong;
      assign next_pd[d]            = drv_pd;
      assign next_family[d*2 +: 2] = drv_family;
    end
  endgenerate

  always_comb begin
    strap_modes = strap_decode(strap_sync);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_o       <= 2'h0;
      pos_oe_o    <= 2'h0;
      neg_o       <= 2'h0;
      neg_oe_o    <= 2'h0;
      family_o    <= 4'h0;
      strong_o    <= 2'h0;
      powerdown_o <= 2'h0;
    end else begin
      pos_o       <= next_pos;
      pos_oe_o    <= next_pos_oe;
      neg_o       <= next_neg;
      neg_oe_o    <= next_neg_oe;
      family_o    <= next_family;
      strong_o    <= next_strong;
      powerdown_o <= next_pd;
    end
  end

endmodule : output_driver_mode_control

/* output_driver_mode_control_asserts.sv */
`timescale 1ns/1ns
module output_driver_mode_control_asserts (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       spi_sclk_i,
  input wire logic       spi_csb_i,
  input wire logic       spi_sdio_i,
  input wire logic       spi_sdio_o,
  input wire logic       spi_sdio_oe_o,
  input wire logic [2:0] output_mode_strap_pins_i,
  input wire logic [1:0] clock_data_i,
  input wire logic [1:0] pos_o,
  input wire logic [1:0] pos_oe_o,
  input wire logic [1:0] neg_o,
  input wire logic [1:0] neg_oe_o,
  input wire logic [3:0] family_o,
  input wire logic [1:0] strong_o,
  input wire logic [1:0] powerdown_o
);
  // ==========================================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cmos_replica: assert property (family_o[1:0] == 2'h1 |-> pos_o[0] == neg_o[0])
    else $error("cmos pins differ");
  a_diff_first: assert property (family_o[1:0] >= 2'h2 && !powerdown_o[0] |->
    neg_o[0] != pos_o[0] && pos_oe_o[0] && neg_oe_o[0]) else $error("first pair wrong");
  a_diff_second: assert property (family_o[3:2] >= 2'h2 && !powerdown_o[1] |->
    neg_o[1] != pos_o[1] && pos_oe_o[1] && neg_oe_o[1]) else $error("second pair wrong");
  a_unused_off: assert property (family_o[1:0] == 2'h0 |-> !pos_oe_o[0] && !neg_oe_o[0])
    else $error("unused code drives");
  a_pd_first: assert property (powerdown_o[0] |->
    !(pos_oe_o[0] | neg_oe_o[0] | pos_o[0] | neg_o[0])) else $error("first not down");
  a_pd_second: assert property (powerdown_o[1] |->
    !(pos_oe_o[1] | neg_oe_o[1] | pos_o[1] | neg_o[1])) else $error("second not down");
  a_strong_family: assert property (strong_o[0] |-> family_o[1:0] inside {2'h1, 2'h2})
    else $error("strong outside cmos or lvds");
  a_diff_latency: assert property (family_o[1:0] == 2'h2 && $past(family_o[1:0], 3) == 2'h2
    && !powerdown_o[0] |-> pos_o[0] == $past(clock_data_i[0], 3))
    else $error("lvds data latency");
  a_sdio_release: assert property ($rose(spi_csb_i) |-> ##[1:8] !spi_sdio_oe_o)
    else $error("sdio held after frame");
  a_sdio_idle: assert property (spi_csb_i [*8] |-> !spi_sdio_oe_o)
    else $error("sdio driven while idle");

  c_lvds: cover property (family_o[1:0] == 2'h2 && !powerdown_o[0]);
  c_cmos: cover property (family_o[1:0] == 2'h1 && strong_o[0]);
  c_read: cover property ($rose(spi_sdio_oe_o));
endmodule : output_driver_mode_control_asserts

bind output_driver_mode_control output_driver_mode_control_asserts asserts_i (.*);

/* test_output_driver_mode_control.sv */
`timescale 1ns/1ns
module test_output_driver_mode_control;
  logic       clk_i, rst_i, sclk, csb, mdat;
  logic [2:0] straps;
  logic [1:0] data, pos_o, pos_oe_o, neg_o, neg_oe_o, strong_o, powerdown_o;
  logic [3:0] family_o;
  logic       sdio_o, sdio_oe;
  int         bad_count, checks;
  wire        sdio = sdio_oe ? sdio_o : mdat;
  localparam logic [5:0] STRAP_TAB [8] = '{6'h2D, 6'h2C, 6'h25, 6'h29, 6'h24, 6'h21, 6'h0C, 6'h09};
  localparam logic [7:0] POL_TAB [3] = '{8'h85, 8'hAD, 8'hA5};

  output_driver_mode_control output_driver_mode_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_csb_i(csb), .spi_sdio_i(sdio),
    .spi_sdio_o(sdio_o), .spi_sdio_oe_o(sdio_oe), .output_mode_strap_pins_i(straps),
    .clock_data_i(data), .pos_o(pos_o), .pos_oe_o(pos_oe_o), .neg_o(neg_o),
    .neg_oe_o(neg_oe_o), .family_o(family_o), .strong_o(strong_o), .powerdown_o(powerdown_o));

  // ==========================================================
  // helpers
  function automatic logic [1:0] fam(input logic [2:0] c);
    return c == 3'h5 ? 2'h3 : c == 3'h4 ? 2'h2 : c < 3'h4 ? 2'h1 : 2'h0;
  endfunction : fam

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic frame(input logic [23:0] w, output logic [7:0] q);
    csb = 1'b0;
    tick(5);
    for (int i = 23; i >= 0; i--) begin
      mdat = w[i];
      tick(5);
      if (i < 8) q[i] = sdio;
      sclk = 1'b1;
      tick(5);
      sclk = 1'b0;
    end
    tick(5);
    csb = 1'b1;
    tick(8);
  endtask : frame

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    frame({3'h0, a, d}, q);
  endtask : wr

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    frame({3'h4, a, 8'hFF}, q);
    chk("readback", e, q);
    chk("sdio_oe", 8'h00, {7'h0, sdio_oe});
  endtask : rd_chk

  task automatic tally_and_finish;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd_chk(13'h0032, output_driver_pkg::CTRL_RESET);
    rd_chk(13'h0034, output_driver_pkg::CTRL_RESET);
    wr(13'h0032, 8'h5A);
    wr(13'h0034, 8'hA4);
    wr(13'h0033, 8'hFF);
    rd_chk(13'h0032, 8'h5A);
    rd_chk(13'h0034, 8'hA4);
    rd_chk(13'h0033, 8'h00);
    wr(13'h0032, 8'h00);
    wr(13'h0034, 8'h00);
  endtask : t_regs

  task automatic t_strap;
    logic [5:0] m;
    logic [3:0] f;
    for (int s = 0; s < 8; s++) begin
      straps = 3'(s);
      tick(6);
      m = STRAP_TAB[s];
      f = {fam(m[2:0]), fam(m[5:3])};
      chk("family", {4'h0, f}, {4'h0, family_o});
      chk("oe", 8'h0F, {4'h0, pos_oe_o, neg_oe_o});
      chk("pos", 8'h01, {6'h0, pos_o});
      chk("neg", {6'h0, f[3:2] != 2'h1, f[1:0] == 2'h1}, {6'h0, neg_o});
    end
  endtask : t_strap

  task automatic t_modes;
    logic [2:0] c;
    wr(13'h0034, 8'h61);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(13'h0032, {2'h0, c, 3'h1});
      chk("family", {4'h0, 2'h2, fam(c)}, {4'h0, family_o});
      chk("oe", {5'h0, c inside {0, 1, 4, 5}, 1'b0, c inside {0, 2, 4, 5}},
          {4'h0, pos_oe_o, neg_oe_o});
      chk("powerdown", 8'h02, {6'h0, powerdown_o});
    end
    wr(13'h0034, 8'h00);
  endtask : t_modes

  task automatic t_pol;
    logic [7:0] v;
    logic       pe;
    for (int i = 0; i < 3; i++) begin
      v = POL_TAB[i];
      pe = !(fam(v[5:3]) == 2'h1 && v[2]);
      wr(13'h0032, v);
      chk("pos true", {7'h0, pe}, {7'h0, pos_o[0]});
      chk("strong", {7'h0, v[7] && fam(v[5:3]) inside {1, 2}}, {7'h0, strong_o[0]});
      data = 2'h0;
      tick(5);
      chk("pos false", {7'h0, !pe}, {7'h0, pos_o[0]});
      data = 2'h1;
    end
    wr(13'h0032, 8'h20);
    straps = 3'h7;
    tick(6);
    chk("source", 8'h01, {6'h0, family_o[1:0]});
  endtask : t_pol

  // ==========================================================
  // run
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    tally_and_finish;
  end

  initial begin
    {rst_i, csb, sclk, mdat, straps, data} = {1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 2'h1};
    bad_count = 0;
    checks = 0;
    tick(2);
    rst_i = 1'b0;
    t_regs;
    t_strap;
    t_modes;
    t_pol;
    tally_and_finish;
  end
endmodule : test_output_driver_mode_control
